// ### verilog/bpsc_ctrl.sv
`timescale 1ns/1ps
module bpsc_ctrl
  import bpsc_pkg::*;
#(
  parameter int NUM_FAULTS = 8, // Protection fault inputs
  parameter int TICK_CYCLES_P = TICK_CYCLES, // Cycles per ms tick
  parameter int CUR_HYST_MA = 50 // Charge/discharge hysteresis, mA
) (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic resetn, // Async reset, active low
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [15:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Register write data
  output logic [15:0] reg_rdata, // Read data, next cycle
  input wire logic cmd_valid, // Host state command strobe
  input wire bpsc_cmd_t cmd_code, // Host state command
  input wire logic afe_comm_fail, // Front-end link failure pin
  input wire logic afe_supply_fault, // Front-end 3.3V supply fault pin
  input wire logic adc_ref_fault, // Converter reference fault pin
  input wire logic [NUM_FAULTS-1:0] fault_in, // Enabled protection faults
  input wire logic [NUM_FAULTS-1:0] fault_rec_en, // Auto-recovery enables
  input wire logic internal_fault, // Internal failure, core domain
  input wire logic load_detect, // Load connected pin
  input wire logic charger_detect, // Charger connected pin
  input wire logic cur_valid, // Current sample strobe
  input wire logic signed [31:0] cur_ma, // Current, mA, charge positive
  input wire logic fe_write, // Controller write to front-end
  output bpsc_fet_t fet_drive, // FET drives
  output bpsc_pwr_t pwr_ctl, // Gauge and controller power
  output logic open_wire_start, // Open-wire check pulse
  output logic mcu_reset, // Watchdog reset pulse
  output bpsc_state_t state_o, // Current state
  output logic [NUM_FAULTS+1:0] alarm_latched // Latched alarms
);

  localparam int TW = $clog2(TICK_CYCLES_P + 1);
  localparam int CW = NUM_FAULTS + 2;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES_P - 1);

  // =====================================================================
  // Helpers
  function automatic logic is_drive(input bpsc_state_t s); // FETs closed
    return s inside {ST_WAKE_DSG, ST_WAKE_CHG, ST_CHARGING, ST_DISCHARGING};
  endfunction

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // =====================================================================
  // Input synchronisers and fault vector
  logic [NUM_FAULTS+4:0] sy; // Synchronised pins
  logic [CW-1:0] cond; // Live alarm conditions
  logic [CW-1:0] rec_vec; // Recovery enables per condition
  logic any_cond; // Some alarm present
  logic nonrec; // Some alarm without recovery
  logic signed [31:0] hyst; // Hysteresis as signed

  bpsc_sync #(.WIDTH(NUM_FAULTS + 5)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({charger_detect, load_detect, adc_ref_fault, afe_supply_fault, afe_comm_fail, fault_in}),
    .sync_out(sy)
  );

  logic [7:0] feat_q; // Feature enables
  logic [15:0] delay_q; // Standby entry delay, s
  logic [15:0] limit_q; // Standby current limit, mA

  // System and sense errors never recover on their own
  assign cond[NUM_FAULTS] = sy[NUM_FAULTS] | sy[NUM_FAULTS+1] | internal_fault;
  assign cond[NUM_FAULTS+1] = feat_q[FEN_ADC_TEST] & sy[NUM_FAULTS+2];
  assign cond[NUM_FAULTS-1:0] = sy[NUM_FAULTS-1:0];
  assign rec_vec = {2'b00, fault_rec_en};
  assign any_cond = |cond;
  assign nonrec = |(cond & ~rec_vec);
  assign hyst = CUR_HYST_MA;

  // =====================================================================
  // Register file; enables are read live by the state logic
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      feat_q <= FEATURE_RST;
      delay_q <= ENTRY_DELAY_RST;
      limit_q <= CUR_LIMIT_RST;
    end
    else if (reg_wr_en)
    begin
      // Writes land at once, no reset needed to apply
      unique case (reg_addr)
        ADDR_FEATURE: feat_q <= reg_wdata[7:0];
        ADDR_ENTRY_DELAY: delay_q <= reg_wdata;
        ADDR_CUR_LIMIT: limit_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  bpsc_state_t state_q; // Current state
  bpsc_state_t state_d; // Next state
  logic [CW-1:0] latch_q; // Latched alarms

  // Read port; unmapped addresses return zero
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd_en)
    begin
      unique case (reg_addr)
        ADDR_FEATURE: reg_rdata <= {8'h00, feat_q};
        ADDR_ENTRY_DELAY: reg_rdata <= delay_q;
        ADDR_CUR_LIMIT: reg_rdata <= limit_q;
        ADDR_STATUS: reg_rdata <= {|latch_q, 6'h00, state_q};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // =====================================================================
  // Millisecond tick; shorten TICK_CYCLES_P in simulation
  logic [TW-1:0] tick_cnt_q;
  logic ms_tick;

  assign ms_tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 1'b1;
  end

  // =====================================================================
  // Front-end watchdog, restarted by each controller write
  logic [15:0] wdt_ms_q;
  logic wdt_exp;

  assign wdt_exp = ms_tick && (wdt_ms_q == WDT_TIMEOUT_MS - 16'h0001);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdt_ms_q <= '0;
      mcu_reset <= 1'b0;
    end
    else
    begin
      if (fe_write || wdt_exp)
        wdt_ms_q <= '0;
      else if (ms_tick)
        wdt_ms_q <= wdt_ms_q + 16'h0001;
      // Expiry only resets the controller when enabled
      mcu_reset <= wdt_exp && feat_q[FEN_WDT_RST];
    end
  end

  // =====================================================================
  // Periodic open-wire check in alarm and safe
  logic [15:0] ow_ms_q;
  logic ow_run;

  assign ow_run = feat_q[FEN_OPEN_WIRE] && (state_q inside {ST_ALARM, ST_SAFE});

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ow_ms_q <= '0;
      open_wire_start <= 1'b0;
    end
    else
    begin
      open_wire_start <= ow_run && ms_tick && (ow_ms_q == OW_PERIOD_MS - 16'h0001);
      if (!ow_run)
        ow_ms_q <= '0;
      else if (ms_tick)
        ow_ms_q <= (ow_ms_q == OW_PERIOD_MS - 16'h0001) ? '0 : ow_ms_q + 16'h0001;
    end
  end

  // =====================================================================
  // Low-current timer for automatic standby
  logic [31:0] cur_q; // Last current sample
  logic [15:0] low_ms_q;
  logic [15:0] low_s_q;
  logic low_run;
  logic sby_due;

  assign low_run = feat_q[FEN_AUTO_SLEEP] && (state_q inside {ST_CHARGING, ST_DISCHARGING})
                   && (mag(cur_q) < {16'h0000, limit_q});
  assign sby_due = low_run && (low_s_q >= delay_q);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_q <= '0;
      low_ms_q <= '0;
      low_s_q <= '0;
    end
    else
    begin
      if (cur_valid)
        cur_q <= cur_ma;
      // Any excursion above the limit restarts the whole wait
      if (!low_run)
      begin
        low_ms_q <= '0;
        low_s_q <= '0;
      end
      else if (ms_tick)
      begin
        low_ms_q <= (low_ms_q == MS_PER_S - 16'h0001) ? '0 : low_ms_q + 16'h0001;
        if (low_ms_q == MS_PER_S - 16'h0001 && low_s_q != 16'hFFFF)
          low_s_q <= low_s_q + 16'h0001;
      end
    end
  end

  // =====================================================================
  // State transitions
  logic is_cmd_sby;
  logic is_cmd_safe;
  logic dsg_cur;
  logic chg_cur;
  bpsc_state_t flt_st; // Destination on a fault
  bpsc_state_t tgt_q; // State after reset-alarm

  assign is_cmd_sby = cmd_valid && (cmd_code == CMD_STANDBY);
  assign is_cmd_safe = cmd_valid && (cmd_code == CMD_SAFE);
  assign dsg_cur = $signed(cur_q) < -hyst;
  assign chg_cur = $signed(cur_q) > hyst;
  assign flt_st = nonrec ? ST_ALARM : ST_AUTO_REC;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_SAFE:
        if (any_cond)
          state_d = flt_st;
        else if (is_cmd_safe)
          state_d = ST_WAKE_DSG;
        else if (is_cmd_sby)
          state_d = ST_LOW_POWER;
        else if (feat_q[FEN_LOAD_DET] && sy[NUM_FAULTS+3])
          state_d = ST_WAKE_DSG;
        else if (feat_q[FEN_CHG_DET] && sy[NUM_FAULTS+4])
          state_d = ST_WAKE_CHG;
      ST_WAKE_DSG, ST_WAKE_CHG:
        if (any_cond)
          state_d = flt_st;
        else if (fet_drive.charging_state && fet_drive.discharge_fet)
          state_d = (state_q == ST_WAKE_DSG) ? ST_DISCHARGING : ST_CHARGING;
      ST_CHARGING, ST_DISCHARGING:
        if (any_cond)
          state_d = flt_st;
        else if (is_cmd_sby || sby_due)
          state_d = ST_LOW_POWER;
        else if (is_cmd_safe)
          state_d = ST_SAFE;
        else if (state_q == ST_CHARGING && dsg_cur)
          state_d = ST_DISCHARGING;
        else if (state_q == ST_DISCHARGING && chg_cur)
          state_d = ST_CHARGING;
      ST_LOW_POWER:
        if (any_cond)
          state_d = ST_ALARM;
        else if (feat_q[FEN_PCH_KEEP] && dsg_cur)
          state_d = ST_WAKE_DSG;
      ST_ALARM:
        // Commands bounce off while any condition is live
        if ((is_cmd_sby || is_cmd_safe) && !any_cond)
          state_d = ST_RESET_ALARM;
      ST_AUTO_REC:
        if (nonrec)
          state_d = ST_ALARM;
        else if (!any_cond)
          state_d = ST_RESET_ALARM;
      ST_RESET_ALARM:
        state_d = tgt_q;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_SAFE;
      tgt_q <= ST_SAFE;
    end
    else
    begin
      state_q <= state_d;
      if (state_d == ST_RESET_ALARM && state_q != ST_RESET_ALARM)
        tgt_q <= (state_q == ST_ALARM && is_cmd_sby) ? ST_LOW_POWER : ST_SAFE;
    end
  end

  // =====================================================================
  // Alarm latch; recovery faults only latch once alarm is taken
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      latch_q <= '0;
    else if (state_q == ST_RESET_ALARM)
      latch_q <= '0;
    else if (state_d == ST_ALARM)
      latch_q <= latch_q | cond;
  end

  // =====================================================================
  // FET drives, following the next state so alarms open them at once
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      fet_drive <= '0;
    else
    begin
      fet_drive.charging_state <= is_drive(state_d);
      fet_drive.discharge_fet <= is_drive(state_d);
      if (state_d == ST_LOW_POWER)
        fet_drive.sby <= feat_q[FEN_PCH_KEEP];
      else if (!is_drive(state_d) || (fet_drive.charging_state && fet_drive.discharge_fet))
        fet_drive.sby <= 1'b0;
    end
  end

  // Gauge goes off first; controller sleeps a cycle later
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pwr_ctl <= '0;
    else
    begin
      pwr_ctl.fg_off <= (state_d == ST_LOW_POWER);
      pwr_ctl.mcu_sleep <= pwr_ctl.fg_off && (state_d == ST_LOW_POWER);
    end
  end

  assign state_o = state_q;
  assign alarm_latched = latch_q;

  // =====================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_lp_entry;
    $rose(state_q == ST_LOW_POWER);
  endsequence

  sequence s_gauge_then_sleep;
    pwr_ctl.fg_off && !pwr_ctl.mcu_sleep ##1 (state_q != ST_LOW_POWER || pwr_ctl.mcu_sleep);
  endsequence

  a_sys_err_alarm: assert property (
    cond[NUM_FAULTS] && is_drive(state_q) |=> state_q == ST_ALARM)
    else $error("system error did not raise alarm");
  a_sense_gated: assert property (
    $rose(latch_q[NUM_FAULTS+1]) |-> $past(feat_q[FEN_ADC_TEST]) && $past(sy[NUM_FAULTS+2]))
    else $error("sense error latched while self-test disabled");
  a_wake_fets: assert property (
    state_q == ST_WAKE_DSG && !any_cond |-> fet_drive.charging_state && fet_drive.discharge_fet ##1 state_q != ST_WAKE_DSG)
    else $error("wake-discharge not transient with FETs closed");
  a_standby_seq: assert property (
    s_lp_entry |-> s_gauge_then_sleep)
    else $error("standby power-down order wrong");
  a_pch_keep: assert property (
    state_q == ST_LOW_POWER && $past(state_q) == ST_LOW_POWER && $past(feat_q[FEN_PCH_KEEP]) |-> fet_drive.sby)
    else $error("standby FET not held in standby");
  a_sby_order: assert property (
    $fell(fet_drive.sby) && is_drive(state_q) |-> $past(fet_drive.charging_state) && $past(fet_drive.discharge_fet))
    else $error("standby FET opened before main FETs closed");
  a_alarm_open: assert property (
    state_q == ST_ALARM |-> !fet_drive.charging_state && !fet_drive.discharge_fet)
    else $error("FETs closed in alarm");
  a_cmd_ignored: assert property (
    state_q == ST_ALARM && any_cond |=> state_q == ST_ALARM)
    else $error("alarm left with condition present");
  a_ow_period: assert property (
    open_wire_start |-> $past(ow_run) && $past(ow_ms_q) == OW_PERIOD_MS - 16'h0001)
    else $error("open-wire check off period");
  a_reset_clears: assert property (
    state_q == ST_RESET_ALARM |=> latch_q == '0 ##0 state_q == $past(tgt_q))
    else $error("reset-alarm did not clear latch");
  a_wdt_bound: assert property (
    wdt_ms_q < WDT_TIMEOUT_MS)
    else $error("watchdog count beyond timeout");

endmodule

// ### verilog/bpsc_pkg.sv
// =====================================================================
// Battery protection state controller shared definitions
package bpsc_pkg;

  // =====================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100; // Core clock period
  localparam int TICK_NS = 1_000_000; // Millisecond time base
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS; // Cycles per ms tick
  localparam logic [15:0] WDT_TIMEOUT_MS = 16'h03E8; // Watchdog expiry, 1 s
  localparam logic [15:0] OW_PERIOD_MS = 16'h2710; // Open-wire period, 10 s
  localparam logic [15:0] MS_PER_S = 16'h03E8; // Milliseconds per second

  // =====================================================================
  // Register map
  localparam logic [15:0] ADDR_ENTRY_DELAY = 16'h7FBD; // Standby entry time, s
  localparam logic [15:0] ADDR_CUR_LIMIT = 16'h7FBF; // Standby current, mA
  localparam logic [15:0] ADDR_FEATURE = 16'h7FC4; // Feature enables
  localparam logic [15:0] ADDR_STATUS = 16'h7F80; // State and latch readback
  localparam logic [15:0] ENTRY_DELAY_RST = 16'h0005; // Reset value
  localparam logic [15:0] CUR_LIMIT_RST = 16'h0064; // Reset value
  localparam logic [7:0] FEATURE_RST = 8'h00; // Reset value

  // Feature enable bit positions
  localparam int FEN_OPEN_WIRE = 0;
  localparam int FEN_LOAD_DET = 1;
  localparam int FEN_CHG_DET = 2;
  localparam int FEN_AUTO_SLEEP = 3;
  localparam int FEN_PCH_KEEP = 4;
  localparam int FEN_WDT_RST = 5;
  localparam int FEN_ADC_TEST = 6;

  // =====================================================================
  // Types
  typedef enum logic [8:0] {
    ST_SAFE = 9'h001,
    ST_WAKE_DSG = 9'h002,
    ST_WAKE_CHG = 9'h004,
    ST_CHARGING = 9'h008,
    ST_DISCHARGING = 9'h010,
    ST_LOW_POWER = 9'h020,
    ST_ALARM = 9'h040,
    ST_AUTO_REC = 9'h080,
    ST_RESET_ALARM = 9'h100
  } bpsc_state_t;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_STANDBY = 2'h1,
    CMD_SAFE = 2'h2
  } bpsc_cmd_t;

  typedef struct packed {
    logic charging_state; // Charge FET closed
    logic discharge_fet; // Discharge FET closed
    logic sby; // Standby discharge FET closed
  } bpsc_fet_t;

  typedef struct packed {
    logic fg_off; // Fuel gauge disabled
    logic mcu_sleep; // Controller asleep
  } bpsc_pwr_t;

endpackage

// ### verilog/bpsc_sync.sv
`timescale 1ns/1ps
// =====================================================================
// Three-stage input synchroniser; output moves once stages 2 and 3 agree
module bpsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Pins from outside
  output logic [WIDTH-1:0] sync_out // Filtered levels
);

  logic [WIDTH-1:0] s1_q; // Metastability stage, read only by s2
  logic [WIDTH-1:0] s2_q; // Second stage
  logic [WIDTH-1:0] s3_q; // Third stage

  // =====================================================================
  // Shift chain and agreement filter
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Hold the old level while the last two stages disagree
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end

endmodule

// ### sim/bpsc_afe_model.sv
`timescale 1ns/1ps
// =====================================================================
// Front-end stand-in: fault pins, detection, current, write pulses
module bpsc_afe_model
  import bpsc_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Reset, active low
  input wire logic [7:0] set_flt, // Requested protection faults
  input wire logic [3:0] set_sys, // Requested sense/system faults
  input wire logic [1:0] set_det, // Requested charger/load
  input wire logic signed [31:0] set_cur, // Requested current, mA
  input wire logic wd_en, // Keep writing to front-end
  output logic [7:0] fault_in, // Protection fault pins
  output logic [3:0] sys_pins, // Adc, internal, supply, comm
  output logic [1:0] det_pins, // Charger, load
  output logic cur_valid, // Sample strobe
  output logic signed [31:0] cur_ma, // Sample value
  output logic fe_write // Write pulse
);
  logic [6:0] cnt_q; // Free running count
  // =====================================================================
  // Pins follow requests one edge late, like a slow comparator
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 7'h00;
      fault_in <= 8'h00;
      sys_pins <= 4'h0;
      det_pins <= 2'h0;
      cur_valid <= 1'b0;
      cur_ma <= 32'sh0000_0000;
      fe_write <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 7'h01;
      fault_in <= set_flt;
      sys_pins <= set_sys;
      det_pins <= set_det;
      cur_valid <= (cnt_q[2:0] == 3'h7); // One sample per 8 cycles
      cur_ma <= set_cur;
      fe_write <= wd_en && (cnt_q == 7'h7F); // Far inside 1 s
    end
  end
endmodule

// ### sim/battery_protection_state_controller_tb.sv
`timescale 1ns/1ps
// =====================================================================
// Drivers note expected states, a monitor checks each change
module battery_protection_state_controller_tb
  import bpsc_pkg::*;
;
  logic core_clk = 1'b0; // 10 MHz
  logic resetn = 1'b0; // Active low
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, cmd_valid = 1'b0, wd_en = 1'b1; // Strobes
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000; // Register bus
  bpsc_cmd_t cmd_code = CMD_NONE; // Host command
  logic [7:0] set_flt = 8'h00, f, fault_rec_en = 8'hFE; // Fault 0 never recovers
  logic [3:0] set_sys = 4'h0; // Sense/system requests
  logic [1:0] set_det = 2'h0; // Charger/load requests
  logic signed [31:0] set_cur = 32'sh0000_0000; // Current request
  logic [7:0] fault_in; // Model pins
  logic [3:0] sys_pins;
  logic [1:0] det_pins;
  logic cur_valid, fe_write, open_wire_start, mcu_reset, rd_d1 = 1'b0;
  logic signed [31:0] cur_ma;
  logic [15:0] reg_rdata; // Design outputs
  bpsc_fet_t fet_drive;
  bpsc_pwr_t pwr_ctl;
  bpsc_state_t state_o, prev_st = ST_SAFE;
  logic [9:0] alarm_latched;
  logic [11:0] stq[$]; // Expected state and FETs
  logic [15:0] rdq[$]; // Expected read data
  logic [31:0] seed = 32'h0000_003D, r; // Xorshift state
  int failures = 0, checks_done = 0, i;
  time t0;

  bpsc_afe_model u_afe (.core_clk, .resetn, .set_flt, .set_sys, .set_det, .set_cur, .wd_en,
    .fault_in, .sys_pins, .det_pins, .cur_valid, .cur_ma, .fe_write);
  // Small tick so seconds, and the 10 s open-wire period, fit the run
  localparam int TK = 2; // Cycles per ms tick in simulation
  bpsc_ctrl #(.NUM_FAULTS(8), .TICK_CYCLES_P(TK), .CUR_HYST_MA(50)) dut (.core_clk, .resetn,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .cmd_valid, .cmd_code,
    .afe_comm_fail(sys_pins[0]), .afe_supply_fault(sys_pins[1]), .adc_ref_fault(sys_pins[3]),
    .fault_in, .fault_rec_en, .internal_fault(sys_pins[2]), .load_detect(det_pins[0]),
    .charger_detect(det_pins[1]), .cur_valid, .cur_ma, .fe_write, .fet_drive, .pwr_ctl,
    .open_wire_start, .mcu_reset, .state_o, .alarm_latched);

  always #50 core_clk = ~core_clk;

  // =====================================================================
  // Helpers
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task fail(input string m);
    failures++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) fail("value mismatch");
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    rdq.push_back(e);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task cmd(input bpsc_cmd_t c);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask
  task ex(input bpsc_state_t s, input logic [2:0] ft);
    stq.push_back({s, ft});
  endtask
  // Bounded wait until every noted state was seen
  task go(input int n);
    int k;
    for (k = 0; k < n && stq.size() != 0; k++) @(posedge core_clk);
    if (stq.size() != 0)
    begin
      fail("state wait timeout");
      stq.delete();
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // =====================================================================
  // Monitor: every state change and read answer takes the oldest note
  always @(posedge core_clk) rd_d1 <= reg_rd_en;
  always @(negedge core_clk)
  begin
    if (resetn && state_o !== prev_st)
    begin
      checks_done++;
      if (stq.size() == 0) fail("unexpected state change");
      else if ({state_o, fet_drive} !== stq.pop_front()) fail("state or FET mismatch");
    end
    prev_st = state_o;
    if (rd_d1)
    begin
      checks_done++;
      if (reg_rdata !== rdq.pop_front()) fail("read data mismatch");
    end
  end

  // Hang guard, about twice the expected run
  initial
  begin
    #9_000_000;
    fail("watchdog expired");
    test_done();
  end

  // =====================================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ADDR_ENTRY_DELAY, ENTRY_DELAY_RST);
    rd(ADDR_CUR_LIMIT, CUR_LIMIT_RST);
    rd(ADDR_FEATURE, 16'h0000);
    rd(16'h7F00, 16'h0000); // Unmapped reads zero
    rd(ADDR_STATUS, 16'h0001);
    $display("test reset done");
    set_det <= 2'h3;
    idle(20); // Detection off: no exit
    set_det <= 2'h0;
    ex(ST_WAKE_DSG, 3'h6);
    ex(ST_DISCHARGING, 3'h6);
    cmd(CMD_SAFE);
    go(20);
    r = xs();
    set_cur <= {27'h000_0000, r[4:0]};
    idle(30);
    set_cur <= 32'sh0000_0050;
    ex(ST_CHARGING, 3'h6);
    go(40);
    r = xs();
    set_cur <= 32'sh0000_0000 - {27'h000_0000, r[4:0]};
    idle(30);
    set_cur <= 32'shFFFF_FFB0;
    ex(ST_DISCHARGING, 3'h6);
    go(40);
    set_cur <= 32'sh0000_0000;
    // Host standby from an active state; option off keeps standby FET open
    ex(ST_LOW_POWER, 3'h0);
    cmd(CMD_STANDBY);
    go(20);
    $display("test hysteresis done");
    r = xs();
    f = {r[7:1], 1'b1};
    set_flt <= f;
    ex(ST_ALARM, 3'h0);
    go(20);
    chk({8'h00, alarm_latched[7:0]}, {8'h00, f});
    cmd(CMD_SAFE);
    idle(10);
    set_flt <= 8'h00;
    idle(8);
    ex(ST_RESET_ALARM, 3'h0);
    ex(ST_SAFE, 3'h0);
    cmd(CMD_SAFE);
    go(20);
    chk({6'h00, alarm_latched}, 16'h0000);
    set_flt <= {r[15:9], 1'b0} | 8'h02;
    ex(ST_AUTO_REC, 3'h0);
    go(20);
    chk({6'h00, alarm_latched}, 16'h0000);
    set_flt <= 8'h00;
    ex(ST_RESET_ALARM, 3'h0);
    ex(ST_SAFE, 3'h0);
    go(20);
    $display("test alarm done");
    set_sys <= 4'h8;
    idle(20); // Self-test off: no sense error
    set_sys <= 4'h0;
    idle(8);
    for (i = 0; i < 4; i++)
    begin
      if (i == 3) wr(ADDR_FEATURE, 16'h0040);
      set_sys <= 4'h1 << i;
      ex(ST_ALARM, 3'h0);
      go(20);
      chk({6'h00, alarm_latched}, (i < 3) ? 16'h0100 : 16'h0200);
      set_sys <= 4'h0;
      idle(8);
      ex(ST_RESET_ALARM, 3'h0);
      // Second pass leaves alarm for standby, the next enters alarm from there
      ex((i == 1) ? ST_LOW_POWER : ST_SAFE, 3'h0);
      cmd((i == 1) ? CMD_STANDBY : CMD_SAFE);
      go(20);
    end
    $display("test errors done");
    wr(ADDR_FEATURE, 16'h0002);
    set_det <= 2'h1;
    ex(ST_WAKE_DSG, 3'h6);
    ex(ST_DISCHARGING, 3'h6);
    go(20);
    set_det <= 2'h0;
    idle(8);
    ex(ST_SAFE, 3'h0);
    cmd(CMD_SAFE);
    go(20);
    wr(ADDR_FEATURE, 16'h0004);
    rd(ADDR_FEATURE, 16'h0004);
    set_det <= 2'h2;
    ex(ST_WAKE_CHG, 3'h6);
    ex(ST_CHARGING, 3'h6);
    go(20);
    set_det <= 2'h0;
    idle(8);
    ex(ST_SAFE, 3'h0);
    cmd(CMD_SAFE);
    go(20);
    $display("test detection done");
    wr(ADDR_ENTRY_DELAY, 16'h0001);
    wr(ADDR_FEATURE, 16'h0018);
    set_cur <= {27'h000_0000, r[20:16]};
    for (i = 0; i < 2; i++)
    begin
      ex(ST_WAKE_DSG, 3'h6);
      ex(ST_DISCHARGING, 3'h6);
      cmd(CMD_SAFE);
      go(20);
      t0 = $time;
      ex(ST_LOW_POWER, 3'h1);
      go(MS_PER_S * TK + 100);
      // One second of low current, less one tick of phase
      chk({15'h0000, ($time - t0) > (MS_PER_S - 16'h0001) * TK * CLK_PERIOD_NS}, 16'h0001);
      idle(2);
      chk({14'h0000, pwr_ctl}, 16'h0003);
      if (i == 0)
      begin
        set_flt <= 8'h01;
        ex(ST_ALARM, 3'h0);
        go(20);
        chk({14'h0000, pwr_ctl}, 16'h0000);
        set_flt <= 8'h00;
        idle(8);
        ex(ST_RESET_ALARM, 3'h0);
        ex(ST_SAFE, 3'h0);
        cmd(CMD_SAFE);
        go(20);
      end
    end
    set_cur <= 32'shFFFF_FF38;
    ex(ST_WAKE_DSG, 3'h7);
    ex(ST_DISCHARGING, 3'h6);
    go(40);
    $display("test standby done");
    ex(ST_SAFE, 3'h0);
    cmd(CMD_SAFE);
    go(20);
    wr(ADDR_FEATURE, 16'h0001);
    // Find one check pulse, then time the next one to the exact cycle
    for (i = 0; i < OW_PERIOD_MS * TK + 50 && open_wire_start !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    for (i = 1; i < OW_PERIOD_MS * TK + 50 && open_wire_start !== 1'b1; i++) @(negedge core_clk);
    chk({15'h0000, i == OW_PERIOD_MS * TK}, 16'h0001);
    $display("test open-wire done");
    @(posedge core_clk);
    wd_en <= 1'b0;
    wr(ADDR_FEATURE, 16'h0020);
    // Last write may lead the stop by up to one 128-cycle model period
    for (i = 0; i < WDT_TIMEOUT_MS * TK + 50 && mcu_reset !== 1'b1; i++) @(negedge core_clk);
    chk({15'h0000, i > WDT_TIMEOUT_MS * TK - 136 && i <= WDT_TIMEOUT_MS * TK && mcu_reset === 1'b1},
      16'h0001);
    @(negedge core_clk);
    chk({15'h0000, mcu_reset}, 16'h0000);
    $display("test watchdog done");
    test_done();
  end
endmodule
